//--- usb_serial_uart_port.sv
// Serial side of a USB bridge: bit timer, transmitter, receiver,
// receive buffer with idle flush, line inversion and power pull-down.
// Assumes pins synchronous to clk and a host that drains on flush.
//
// Function
// - The bit rate is the 3 MHz base divided by integer n plus fraction x.
// - The integer part n takes any value 2 to 16384, written 0 for 16384.
// - The fraction x is in eighths, 0 to 0.875, held in three bits.
// - A divisor of exactly one works, and nothing between one and two exists.
// - Standard and odd rates from 300 baud to 3 megabaud are reachable.
// - An idle receive timeout, 16 ms after reset, flushes buffered data.
// - The timeout is an 8-bit millisecond count, 1 to 255 ms.
// - Each of the eight serial lines has its own polarity inversion bit.
// - With the option set and power switch off, the lines are pulled low.
// - A fixed identity number is readable and no write changes it.
// - The transmit line is driven as an output carrying serial data.
// - Request-to-send is driven as an active-low output.
// - Terminal-ready is driven as an active-low output.
`include "uart_port_defs.svh"
`default_nettype none

module usb_serial_uart_port
  import uart_port_pkg::*;
#(
  parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS,
  // Arbitrary identity value
  parameter logic [31:0] CHIP_ID = 32'h1234ABCD
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // Serial lines
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  output logic dtr_n,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  // Power control
  input wire logic power_switch_on_n,
  output logic uart_pulldown_en,
  // Host side
  output logic rx_flush
);

  localparam int MS_W = $clog2(MS_CYCLES + 1);

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [16:0] div_ff, nxt_div;
  logic [4:0] line_ff, nxt_line;
  logic [7:0] inv_ff, nxt_inv;
  logic [7:0] tmo_ff, nxt_tmo;
  logic [2:0] stk_ff, nxt_stk;
  logic [3:0] pin_st_ff, nxt_pin_st;
  logic [31:0] reg_rdata_ff, nxt_rdata;
  logic rts_n_ff, nxt_rts_n, dtr_n_ff, nxt_dtr_n, pdn_ff, nxt_pdn;
  logic [17:0] div8;
  logic [3:0] pin_vec, inv_in, pin_act;
  tx_state_t tx_st_ff, nxt_tx_st;
  logic [7:0] tx_sh_ff, nxt_tx_sh, tx_hold_ff, nxt_tx_hold;
  logic [2:0] tx_cnt_ff, nxt_tx_cnt;
  logic tx_stop2_ff, nxt_tx_stop2, tx_pend_ff, nxt_tx_pend;
  logic txd_ff, nxt_txd, tx_lvl, tx_done;
  rx_state_t rx_st_ff, nxt_rx_st;
  logic [7:0] rx_sh_ff, nxt_rx_sh, mem_rd;
  logic [2:0] rx_cnt_ff, nxt_rx_cnt;
  logic rxd_ff, nxt_rxd;
  logic [3:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [MS_W-1:0] ms_ff, nxt_ms;
  logic [7:0] idle_ms_ff, nxt_idle_ms;
  logic armed_ff, nxt_armed, flush_ff, nxt_flush;
  logic push, pop, ovr_evt, ferr_evt;

  baud_if tx_bif ();
  baud_if rx_bif ();

  baud_gen u_tx_baud (.clk(clk), .rst_n(rst_n), .ce(ce), .bif(tx_bif));
  baud_gen u_rx_baud (.clk(clk), .rst_n(rst_n), .ce(ce), .bif(rx_bif));

  rx_buf_mem u_rx_mem (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .we(push), .waddr(wr_ptr_ff), .wdata(rx_sh_ff),
    .raddr(nxt_rd_ptr), .rdata(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input lines with per-line polarity
  assign pin_vec = {ri_n, dcd_n, dsr_n, cts_n};
  assign inv_in = {inv_ff[`INV_RI], inv_ff[`INV_DCD], inv_ff[`INV_DSR], inv_ff[`INV_CTS]};

  // one inversion bit per input line
  // clear-to-send taken as asserted when low
  for (genvar i = 0; i < 4; i++)
  begin : g_pin
    assign pin_act[i] = ~(pin_vec[i] ^ inv_in[i]);
  end

  // n of zero stands for 16384
  assign div8 = {(div_ff[`DIV_N_MSB:0] == 14'h0) ? `DIV_N_WRAP
                 : {1'b0, div_ff[`DIV_N_MSB:0]}, div_ff[`DIV_X_MSB:`DIV_X_LSB]};

  ////////////////////////////////////////////////////////////////////////////
  // Registers and control outputs
  always_comb
  begin
    nxt_div = div_ff;
    nxt_line = line_ff;
    nxt_inv = inv_ff;
    nxt_tmo = tmo_ff;
    nxt_rdata = 32'h0;
    nxt_pin_st = pin_act;
    nxt_stk = stk_ff;
    if (reg_we && hit(reg_addr, `OFS_STATUS))
      nxt_stk = stk_ff & ~reg_wdata[`ST_STK_MSB:`ST_STK_LSB];
    // Events set after the clear, so a same-cycle event survives
    nxt_stk = nxt_stk | {nxt_flush, ferr_evt, ovr_evt};
    if (reg_we)
    begin
      // n of one forces a zero fraction
      if (hit(reg_addr, `OFS_DIV))
        nxt_div = {(reg_wdata[`DIV_N_MSB:0] == 14'h1) ? 3'h0
                   : reg_wdata[`DIV_X_MSB:`DIV_X_LSB], reg_wdata[`DIV_N_MSB:0]};
      if (hit(reg_addr, `OFS_LINE))
        nxt_line = reg_wdata[4:0];
      if (hit(reg_addr, `OFS_INV))
        nxt_inv = reg_wdata[7:0];
      // zero is raised to one millisecond
      if (hit(reg_addr, `OFS_TMO))
        nxt_tmo = (reg_wdata[7:0] == 8'h0) ? 8'h01 : reg_wdata[7:0];
    end
    if (reg_re)
    begin
      case (reg_addr)
        `OFS_DIV: nxt_rdata = {15'h0, div_ff};
        `OFS_LINE: nxt_rdata = {27'h0, line_ff};
        `OFS_INV: nxt_rdata = {24'h0, inv_ff};
        `OFS_TMO: nxt_rdata = {24'h0, tmo_ff};
        `OFS_RXDATA: nxt_rdata = (cnt_ff != 5'h0) ? {24'h0, mem_rd} : 32'h0;
        `OFS_STATUS: nxt_rdata = {11'h0, cnt_ff, 4'h0, pin_st_ff, 2'h0, tx_pend_ff,
                                  stk_ff, (cnt_ff != 5'h0), (tx_st_ff != TX_IDLE)};
        // identity is a constant, no write path reaches it
        `OFS_CHIPID: nxt_rdata = CHIP_ID;
        default: nxt_rdata = 32'h0;
      endcase
    end
    nxt_rts_n = ~line_ff[`LINE_RTS] ^ inv_ff[`INV_RTS];
    nxt_dtr_n = ~line_ff[`LINE_DTR] ^ inv_ff[`INV_DTR];
    // bleed lines while external power is off
    nxt_pdn = line_ff[`LINE_PDN] && power_switch_on_n;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_ff <= `RST_DIV;
      line_ff <= 5'h00;
      inv_ff <= 8'h00;
      tmo_ff <= `RST_TMO;
      stk_ff <= 3'h0;
      pin_st_ff <= 4'h0;
      reg_rdata_ff <= 32'h0;
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
      pdn_ff <= 1'b0;
    end
    else if (ce)
    begin
      div_ff <= nxt_div;
      line_ff <= nxt_line;
      inv_ff <= nxt_inv;
      tmo_ff <= nxt_tmo;
      stk_ff <= nxt_stk;
      pin_st_ff <= nxt_pin_st;
      reg_rdata_ff <= nxt_rdata;
      rts_n_ff <= nxt_rts_n;
      dtr_n_ff <= nxt_dtr_n;
      pdn_ff <= nxt_pdn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_bif.div8 = div8;
  assign tx_bif.restart = (tx_st_ff == TX_IDLE);
  assign tx_bif.half = 1'b0;

  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_stop2 = tx_stop2_ff;
    nxt_tx_pend = tx_pend_ff;
    nxt_tx_hold = tx_hold_ff;
    tx_done = 1'b0;
    // A byte written while one is pending is dropped
    if (reg_we && hit(reg_addr, `OFS_TXDATA) && !tx_pend_ff)
    begin
      nxt_tx_pend = 1'b1;
      nxt_tx_hold = reg_wdata[7:0];
    end
    case (tx_st_ff)
      TX_IDLE:
        // hold off a new character while clear-to-send is off
        if (tx_pend_ff && (!line_ff[`LINE_FLOW] || pin_act[0]))
        begin
          nxt_tx_st = TX_START;
          nxt_tx_sh = tx_hold_ff;
          nxt_tx_pend = 1'b0;
        end
      TX_START:
        if (tx_bif.tick)
        begin
          nxt_tx_st = TX_DATA;
          nxt_tx_cnt = 3'h0;
        end
      TX_DATA:
        if (tx_bif.tick)
        begin
          nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
          nxt_tx_cnt = tx_cnt_ff + 3'h1;
          if (tx_cnt_ff == 3'h7)
          begin
            nxt_tx_st = TX_STOP;
            nxt_tx_stop2 = line_ff[`LINE_STOP2];
          end
        end
      TX_STOP:
        if (tx_bif.tick)
        begin
          if (tx_stop2_ff)
            nxt_tx_stop2 = 1'b0;
          else
          begin
            nxt_tx_st = TX_IDLE;
            tx_done = 1'b1;
          end
        end
      default: nxt_tx_st = TX_IDLE;
    endcase
    // low start, high stop and idle
    tx_lvl = (tx_st_ff == TX_START) ? 1'b0 : ((tx_st_ff == TX_DATA) ? tx_sh_ff[0] : 1'b1);
    // transmit line driven with its own inversion
    nxt_txd = tx_lvl ^ inv_ff[`INV_TXD];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= 8'h00;
      tx_cnt_ff <= 3'h0;
      tx_stop2_ff <= 1'b0;
      tx_pend_ff <= 1'b0;
      tx_hold_ff <= 8'h00;
      txd_ff <= 1'b1;
    end
    else if (ce)
    begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_stop2_ff <= nxt_tx_stop2;
      tx_pend_ff <= nxt_tx_pend;
      tx_hold_ff <= nxt_tx_hold;
      txd_ff <= nxt_txd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver, buffer pointers and idle flush
  assign rx_bif.div8 = div8;
  assign rx_bif.restart = (rx_st_ff == RX_IDLE);
  assign rx_bif.half = (rx_st_ff == RX_START);

  always_comb
  begin
    // receive line sampled with its own inversion
    nxt_rxd = rxd ^ inv_ff[`INV_RXD];
    nxt_rx_st = rx_st_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    push = 1'b0;
    ovr_evt = 1'b0;
    ferr_evt = 1'b0;
    case (rx_st_ff)
      RX_IDLE:
        if (!rxd_ff)
          nxt_rx_st = RX_START;
      RX_START:
        // Start bit rechecked mid-bit to reject glitches
        if (rx_bif.tick)
        begin
          nxt_rx_st = rxd_ff ? RX_IDLE : RX_DATA;
          nxt_rx_cnt = 3'h0;
        end
      RX_DATA:
        if (rx_bif.tick)
        begin
          nxt_rx_sh = {rxd_ff, rx_sh_ff[7:1]};
          nxt_rx_cnt = rx_cnt_ff + 3'h1;
          if (rx_cnt_ff == 3'h7)
            nxt_rx_st = RX_STOP;
        end
      RX_STOP:
        // a low stop bit is a framing error
        if (rx_bif.tick)
        begin
          nxt_rx_st = RX_IDLE;
          ferr_evt = !rxd_ff;
          push = rxd_ff && (cnt_ff != 5'h10);
          ovr_evt = rxd_ff && (cnt_ff == 5'h10);
        end
      default: nxt_rx_st = RX_IDLE;
    endcase
    pop = reg_re && hit(reg_addr, `OFS_RXDATA) && (cnt_ff != 5'h0);
    nxt_wr_ptr = wr_ptr_ff + {3'h0, push};
    nxt_rd_ptr = rd_ptr_ff + {3'h0, pop};
    nxt_cnt = cnt_ff + {4'h0, push} - {4'h0, pop};
    nxt_flush = 1'b0;
    nxt_ms = ms_ff;
    nxt_idle_ms = idle_ms_ff;
    nxt_armed = armed_ff;
    // leftover bytes flushed after the idle time
    if (push)
    begin
      nxt_armed = 1'b1;
      nxt_ms = '0;
      nxt_idle_ms = 8'h00;
    end
    else if (armed_ff && (cnt_ff != 5'h0))
    begin
      if (ms_ff == MS_W'(MS_CYCLES - 1))
      begin
        nxt_ms = '0;
        nxt_idle_ms = idle_ms_ff + 8'h01;
        if (idle_ms_ff + 8'h01 >= tmo_ff)
        begin
          nxt_flush = 1'b1;
          nxt_armed = 1'b0;
          nxt_idle_ms = 8'h00;
        end
      end
      else
        nxt_ms = ms_ff + MS_W'(1);
    end
    else
    begin
      nxt_ms = '0;
      nxt_idle_ms = 8'h00;
      nxt_armed = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rxd_ff <= 1'b1;
      rx_st_ff <= RX_IDLE;
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 3'h0;
      wr_ptr_ff <= 4'h0;
      rd_ptr_ff <= 4'h0;
      cnt_ff <= 5'h00;
      ms_ff <= '0;
      idle_ms_ff <= 8'h00;
      armed_ff <= 1'b0;
      flush_ff <= 1'b0;
    end
    else if (ce)
    begin
      rxd_ff <= nxt_rxd;
      rx_st_ff <= nxt_rx_st;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      ms_ff <= nxt_ms;
      idle_ms_ff <= nxt_idle_ms;
      armed_ff <= nxt_armed;
      flush_ff <= nxt_flush;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign txd = txd_ff;
  assign rts_n = rts_n_ff;
  assign dtr_n = dtr_n_ff;
  assign uart_pulldown_en = pdn_ff;
  assign rx_flush = flush_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_DIV_ONE: assert property (
    ce && reg_we && hit(reg_addr, `OFS_DIV) && reg_wdata[13:0] == 14'h1 |=> div8 == 18'h8)
    else $error("divisor of one kept a fraction");
  AST_DIV_WRAP: assert property (
    div_ff[13:0] == 14'h0 |-> div8[17:3] == 15'h4000)
    else $error("n of zero not read as 16384");
  AST_DIV_FRAC: assert property (
    div_ff[13:0] != 14'h0 |-> div8 == {1'b0, div_ff[13:0], div_ff[16:14]})
    else $error("divisor fraction lost");
  AST_TMO_RANGE: assert property (tmo_ff != 8'h0)
    else $error("timeout reached zero");
  AST_TMO_DEFAULT: assert property ($rose(rst_n) |-> tmo_ff == 8'h10)
    else $error("timeout not 16 ms after reset");
  AST_FLUSH_ONCE: assert property (flush_ff |-> !armed_ff ##1 !flush_ff)
    else $error("flush repeated without new data");
  AST_CHIP_ID: assert property (
    ce && reg_re && hit(reg_addr, `OFS_CHIPID) |=> reg_rdata_ff == CHIP_ID)
    else $error("identity read wrong");
  AST_PULLDOWN: assert property (
    ce && !reg_we && line_ff[`LINE_PDN] && power_switch_on_n |=> pdn_ff)
    else $error("pull-down not applied");
  AST_TX_START: assert property (
    ce && !reg_we && tx_st_ff == TX_START |=> txd_ff == inv_ff[`INV_TXD])
    else $error("start bit not low");
  AST_TX_IDLE: assert property (
    ce && !reg_we && tx_st_ff == TX_IDLE |=> txd_ff == !inv_ff[`INV_TXD])
    else $error("idle line level wrong");
  AST_RTS: assert property (
    ce && !reg_we && line_ff[`LINE_RTS] && !inv_ff[`INV_RTS] |=> !rts_n_ff)
    else $error("request-to-send not low");
  AST_DTR: assert property (
    ce && !reg_we && line_ff[`LINE_DTR] && !inv_ff[`INV_DTR] |=> !dtr_n_ff)
    else $error("terminal-ready not low");

  COV_TX_DONE: cover property (tx_done);
  COV_RX_PUSH: cover property (push);
  COV_FLUSH: cover property (flush_ff);
  COV_CTS_HOLD: cover property (tx_pend_ff && line_ff[`LINE_FLOW] && !pin_act[0]);

endmodule

`default_nettype wire

//--- uart_port_defs.svh
// Register offsets, field positions, reset values and timing figures.
// Assumes a single 40 MHz clock and a 4-bit register word address.
`ifndef UART_PORT_DEFS_SVH
`define UART_PORT_DEFS_SVH

// Register word addresses
`define OFS_DIV 4'h0
`define OFS_LINE 4'h1
`define OFS_INV 4'h2
`define OFS_TMO 4'h3
`define OFS_TXDATA 4'h4
`define OFS_RXDATA 4'h5
`define OFS_STATUS 4'h6
`define OFS_CHIPID 4'h7

// Divisor fields
`define DIV_N_MSB 13
`define DIV_X_LSB 14
`define DIV_X_MSB 16
`define DIV_N_WRAP 15'h4000

// Line control bits
`define LINE_RTS 0
`define LINE_DTR 1
`define LINE_FLOW 2
`define LINE_PDN 3
`define LINE_STOP2 4

// Inversion bits, one per line
`define INV_TXD 0
`define INV_RXD 1
`define INV_RTS 2
`define INV_CTS 3
`define INV_DTR 4
`define INV_DSR 5
`define INV_DCD 6
`define INV_RI 7

// Status layout; sticky bits are write-one-to-clear
`define ST_STK_LSB 2
`define ST_STK_MSB 4
`define ST_PIN_LSB 8
`define ST_CNT_LSB 16

// Reset values
`define RST_DIV 17'h10138
`define RST_TMO 8'h10

// Timing: bit period = CLK_HZ * D / BASE_HZ in clock units
`define BASE_HZ 3000000
`define CLK_HZ 40000000
`define SCALE_HZ 1000000
`define ACC_STEP (2 * 8 * `BASE_HZ / `SCALE_HZ)
`define LIM_PER_DIV (`CLK_HZ / `SCALE_HZ)
`define CLK_PERIOD_NS 25
`define MS_NS 1000000

`endif

//--- uart_port_pkg.sv
// Types shared by the serial port modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package uart_port_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

`default_nettype wire

//--- baud_if.sv
// Carrier between a bit timer and the engine that uses it.
// Assumes both ends share one clock.
`default_nettype none

interface baud_if;
  logic [17:0] div8;
  logic restart;
  logic half;
  logic tick;
  modport gen (input div8, input restart, input half, output tick);
  modport user (output div8, output restart, output half, input tick);
endinterface

`default_nettype wire

//--- baud_gen.sv
// Fractional bit timer: ticks once per bit, or per half bit.
// Assumes the divisor is held in eighths and never below 8.
`include "uart_port_defs.svh"
`default_nettype none

module baud_gen
  import uart_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Timer carrier
  baud_if.gen bif
);

  logic [24:0] acc_ff;
  logic [24:0] nxt_acc;
  logic [24:0] limit;
  logic [24:0] sum;
  logic tick_c;

  // base rate divided by n plus x
  // residual kept, so slow and odd rates stay exact on average
  always_comb
  begin
    limit = 25'(bif.div8) * 25'(`LIM_PER_DIV);
    if (!bif.half)
      limit = {limit[23:0], 1'b0};
    sum = acc_ff + 25'(`ACC_STEP);
    tick_c = ce && !bif.restart && (sum >= limit);
    nxt_acc = bif.restart ? 25'h0 : (tick_c ? sum - limit : sum);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      acc_ff <= 25'h0;
    else if (ce)
      acc_ff <= nxt_acc;
  end

  assign bif.tick = tick_c;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TICK_GAP: assert property (bif.tick |=> !bif.tick [*5])
    else $error("bit timer ticked too soon");

endmodule

`default_nettype wire

//--- rx_buf_mem.sv
// Receive buffer storage, sixteen bytes, registered read port.
// Assumes the caller keeps pointers; a write to the read address bypasses.
`default_nettype none

module rx_buf_mem
  import uart_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Write side
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  // Read side
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem_ff [16];
  logic [7:0] rd_ff;
  logic [7:0] nxt_rd;

  // Bypass keeps a byte written to an empty buffer readable at once
  always_comb
  begin
    nxt_rd = (we && (waddr == raddr)) ? wdata : mem_ff[raddr];
  end

  always_ff @(posedge clk)
  begin
    if (ce && we)
      mem_ff[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_ff <= 8'h00;
    else if (ce)
      rd_ff <= nxt_rd;
  end

  assign rdata = rd_ff;

endmodule

`default_nettype wire

//--- serial_peer.sv
// Serial peer model: sends and captures characters, drives handshakes.
// Assumes a bit time of BIT clk cycles, matching the programmed divisor.
`default_nettype none

module serial_peer #(
  parameter int BIT = 40
)
(
  // Clock
  input wire logic clk,
  // Serial lines, handshakes as {cts, dsr, dcd, ri}
  input wire logic txd,
  output logic rxd,
  output logic [3:0] ctl_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    rxd = 1'b1;
    ctl_n = 4'hF;
  end

  task automatic set_ctl(input logic [3:0] v);
    @(posedge clk);
    ctl_n <= v;
  endtask

  // start low, LSB first, stop bit at the level given by stop
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge clk);
    end
    // Line back to idle, even after a bad stop bit
    @(posedge clk);
    rxd <= 1'b1;
  endtask

  // mid-bit sampling, stop must be high
  // Falling edges keep sampling clear of the edge that launches txd
  task automatic capture(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
      return;
    repeat (BIT / 2) @(negedge clk);
    ok = (txd === 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(negedge clk);
      b[i] = txd;
    end
    repeat (BIT) @(negedge clk);
    ok = ok && (txd === 1'b1);
  endtask
endmodule

`default_nettype wire

//--- tb_top.sv
// Testbench: register accesses, serial traffic through the peer model.
// Assumes divisor n=3 gives 40 clk cycles per bit at 40 MHz.
`include "uart_port_defs.svh"
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [31:0] ID = 32'h5A5A0001;
  logic clk, rst_n, reg_we, reg_re, pwr_n, ce;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic txd, rxd, rts_n, dtr_n, pd_en, rx_flush, ok;
  logic [3:0] ctl_n;
  logic [7:0] b;
  int errors, samples_checked, n;

  usb_serial_uart_port #(.MS_CYCLES(20), .CHIP_ID(ID)) DUT (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n), .dtr_n(dtr_n),
    .cts_n(ctl_n[3]), .dsr_n(ctl_n[2]), .dcd_n(ctl_n[1]), .ri_n(ctl_n[0]),
    .power_switch_on_n(pwr_n), .uart_pulldown_en(pd_en), .rx_flush(rx_flush)
  );

  serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd), .ctl_n(ctl_n));

  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Data stands only in the cycle after the read edge
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    rd(a, d);
    chk(d, e);
  endtask

  // Registered outputs need two edges after the write
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    pwr_n = 1'b0;
    ce = 1'b1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({29'h0, txd, rts_n, dtr_n}, 32'h7);
    rdchk(`OFS_DIV, {15'h0, `RST_DIV});
    rdchk(`OFS_TMO, {24'h0, `RST_TMO});
    rdchk(`OFS_CHIPID, ID);
    wr(`OFS_CHIPID, 32'h0);
    rdchk(`OFS_CHIPID, ID);
    rdchk(4'hF, 32'h0);
    $display("test reset done");
    wr(`OFS_DIV, {15'h0, 3'h5, 14'h1});
    rdchk(`OFS_DIV, 32'h1);
    wr(`OFS_DIV, {15'h0, 3'h7, 14'h0});
    rdchk(`OFS_DIV, 32'h1C000);
    wr(`OFS_DIV, 32'h2);
    rdchk(`OFS_DIV, 32'h2);
    wr(`OFS_TMO, 32'h0);
    rdchk(`OFS_TMO, 32'h1);
    wr(`OFS_TMO, 32'hFF);
    rdchk(`OFS_TMO, 32'hFF);
    $display("test divisor and timeout done");
    wr(`OFS_LINE, 32'h3);
    settle();
    chk({30'h0, rts_n, dtr_n}, 32'h0);
    wr(`OFS_INV, 32'h15);
    settle();
    chk({29'h0, txd, rts_n, dtr_n}, 32'h3);
    peer.set_ctl(4'h6);
    wr(`OFS_INV, 32'h0);
    settle();
    rd(`OFS_STATUS, d);
    chk({28'h0, d[11:8]}, 32'h9);
    wr(`OFS_INV, 32'h08);
    settle();
    rd(`OFS_STATUS, d);
    chk({28'h0, d[11:8]}, 32'h8);
    wr(`OFS_INV, 32'h0);
    $display("test lines and inversion done");
    wr(`OFS_LINE, 32'h8);
    pwr_n <= 1'b1;
    settle();
    chk1(pd_en, 1'b1);
    @(posedge clk);
    pwr_n <= 1'b0;
    settle();
    chk1(pd_en, 1'b0);
    $display("test pull-down done");
    // Write under a low enable must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(`OFS_TMO, 32'h7);
    @(posedge clk);
    ce <= 1'b1;
    rdchk(`OFS_TMO, 32'hFF);
    $display("test clock enable done");
    wr(`OFS_DIV, 32'h3);
    wr(`OFS_TXDATA, 32'hA5);
    peer.capture(b, ok);
    chk({23'h0, ok, b}, 32'h1A5);
    peer.set_ctl(4'hF);
    wr(`OFS_LINE, 32'h4);
    wr(`OFS_TXDATA, 32'h3C);
    repeat (200) @(negedge clk);
    chk1(txd, 1'b1);
    peer.set_ctl(4'h7);
    peer.capture(b, ok);
    chk({23'h0, ok, b}, 32'h13C);
    $display("test transmit done");
    wr(`OFS_TMO, 32'h3);
    peer.send(8'h96, 1'b1);
    n = 0;
    while (rx_flush !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    // Byte stored mid-stop, about half a bit before send returns
    chk1(n >= 35 && n <= 50, 1'b1);
    rd(`OFS_STATUS, d);
    chk({30'h0, d[4], d[1]}, 32'h3);
    rdchk(`OFS_RXDATA, 32'h96);
    $display("test receive and flush done");
    // Low stop bit: byte dropped, then a released line is a rejected start
    peer.send(8'h5A, 1'b0);
    rd(`OFS_STATUS, d);
    chk({26'h0, d[3], d[20:16]}, 32'h20);
    wr(`OFS_STATUS, 32'h1C);
    rdchk(`OFS_STATUS, 32'h100);
    $display("test frame error done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
